//--- verilog/system_reset_lowpower_ctrl.sv
// module: reset cause, scratch words and low-power gating control
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module system_reset_lowpower_ctrl
#(
  parameter logic [15:0] CHIP_ID_HI = 16'hA5C3, // arbitrary value
  parameter logic [15:0] CHIP_ID_LO = 16'h3C5A // arbitrary value
)
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic [4:0] ADDR,
  input wire logic [15:0] WR_DATA,
  input wire logic WR_EN,
  input wire logic RD_EN,
  output logic [15:0] RD_DATA,
  input wire logic EXT_RESET_N,
  input wire logic WDOG_TIMEOUT,
  input wire logic WDOG_REFLOSS,
  input wire logic STOP_EXEC,
  input wire logic WAIT_EXEC,
  output logic STOP_ENTER,
  output logic WAIT_ENTER,
  output logic REG_STANDBY,
  output logic SYS_RESET,
  output logic WDOG_VECTOR
);

  ////////////////////////////////////////////////////////////////////
  // state and bus bundle

  rlp_pkg::state_t s_q;
  rlp_pkg::state_t s_d;
  rlp_pkg::req_t req;
  logic sys_evt;
  logic [4:0] scr_off;
  logic [1:0] scr_idx;
  logic scr_hit;

  // bundle the register port
  assign req.addr = ADDR;
  assign req.wdata = WR_DATA;
  assign req.wr = WR_EN;
  assign req.rd = RD_EN;

  ////////////////////////////////////////////////////////////////////
  // helper functions

  // locked field keeps its value, else takes the write
  function automatic rlp_pkg::gate_t upd_field
  (
    input rlp_pkg::gate_t cur,
    input logic hit,
    input rlp_pkg::gate_t nxt
  );
    rlp_pkg::gate_t res;
    res = cur;
    if (hit && !cur[1])
    begin
      res = nxt;
    end
    return res;
  endfunction

  // highest active source wins
  function automatic logic [4:0] pick_cause
  (
    input logic ext,
    input logic lo,
    input logic to,
    input logic sw
  );
    logic [4:0] res;
    res = rlp_pkg::CAUSE_SW;
    if (ext)
    begin
      res = rlp_pkg::CAUSE_EXT;
    end
    else if (lo)
    begin
      res = rlp_pkg::CAUSE_REFLOSS;
    end
    else if (to)
    begin
      res = rlp_pkg::CAUSE_TIMEOUT;
    end
    else if (sw)
    begin
      res = rlp_pkg::CAUSE_SW;
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // decode

  // any non-power-on reset source this cycle
  assign sys_evt = s_q.ext_s | WDOG_REFLOSS | WDOG_TIMEOUT
    | s_q.swr_pend;

  // scratch window
  assign scr_off = req.addr - rlp_pkg::OFF_SCRATCH;
  assign scr_idx = scr_off[1:0];
  assign scr_hit = (req.addr >= rlp_pkg::OFF_SCRATCH)
    && (scr_off < 5'(rlp_pkg::NUM_SCRATCH));

  ////////////////////////////////////////////////////////////////////
  // next state

  // whole block next state
  always_comb
  begin
    s_d = s_q;
    // pin synchroniser
    s_d.ext_m = ~EXT_RESET_N;
    s_d.ext_s = s_q.ext_m;
    s_d.swr_pend = 1'b0;
    s_d.sys_rst = 1'b0;
    s_d.stop_ent = 1'b0;
    s_d.wait_ent = 1'b0;
    s_d.rd_data = 16'h0000;
    if (RST)
    begin
      // power-on clears the fields and scratch, cause set to power-on
      s_d.stop_fld = rlp_pkg::FIELD_RST;
      s_d.wait_fld = rlp_pkg::FIELD_RST;
      s_d.stby_fld = rlp_pkg::FIELD_RST;
      s_d.cause = rlp_pkg::CAUSE_RST;
      for (int i = 0; i < rlp_pkg::NUM_SCRATCH; i++)
      begin
        s_d.scratch[i] = rlp_pkg::SCRATCH_RST;
      end
    end
    else if (sys_evt)
    begin
      // system reset: defaults, scratch kept
      s_d.stop_fld = rlp_pkg::FIELD_RST;
      s_d.wait_fld = rlp_pkg::FIELD_RST;
      s_d.stby_fld = rlp_pkg::FIELD_RST;
      s_d.cause = pick_cause(s_q.ext_s, WDOG_REFLOSS,
        WDOG_TIMEOUT, s_q.swr_pend);
      s_d.sys_rst = 1'b1;
    end
    else
    begin
      // register writes
      if (req.wr && req.addr == rlp_pkg::OFF_CTRL)
      begin
        s_d.stop_fld = upd_field(s_q.stop_fld, 1'b1,
          req.wdata[rlp_pkg::CTRL_STOP_LSB +: 2]);
        s_d.wait_fld = upd_field(s_q.wait_fld, 1'b1,
          req.wdata[rlp_pkg::CTRL_WAIT_LSB +: 2]);
        s_d.swr_pend = req.wdata[rlp_pkg::CTRL_SOFTWARE_RESET_TRIGGER_BIT];
      end
      if (req.wr && req.addr == rlp_pkg::OFF_PWR)
      begin
        s_d.stby_fld = upd_field(s_q.stby_fld, 1'b1,
          req.wdata[rlp_pkg::PWR_STBY_LSB +: 2]);
      end
      if (req.wr && scr_hit)
      begin
        s_d.scratch[scr_idx] = req.wdata;
      end
      // gated low-power entry
      s_d.stop_ent = STOP_EXEC & ~s_q.stop_fld[0];
      s_d.wait_ent = WAIT_EXEC & ~s_q.wait_fld[0];
    end
    // reads answer in every cycle but power-on
    if (req.rd && !RST)
    begin
      case (req.addr)
        rlp_pkg::OFF_CTRL:
        begin
          s_d.rd_data[rlp_pkg::CTRL_STOP_LSB +: 2] = s_q.stop_fld;
          s_d.rd_data[rlp_pkg::CTRL_WAIT_LSB +: 2] = s_q.wait_fld;
        end
        rlp_pkg::OFF_CAUSE:
        begin
          s_d.rd_data[rlp_pkg::CAUSE_LSB +: 5] = s_q.cause;
        end
        rlp_pkg::OFF_CHIP_HI:
        begin
          s_d.rd_data = CHIP_ID_HI;
        end
        rlp_pkg::OFF_CHIP_LO:
        begin
          s_d.rd_data = CHIP_ID_LO;
        end
        rlp_pkg::OFF_PWR:
        begin
          s_d.rd_data[rlp_pkg::PWR_STBY_LSB +: 2] = s_q.stby_fld;
        end
        default:
        begin
          if (scr_hit)
          begin
            s_d.rd_data = s_q.scratch[scr_idx];
          end
        end
      endcase
    end
    // outputs from the settled fields
    s_d.wdog_vec = s_d.cause[2] | s_d.cause[3];
    s_d.stby_out = s_d.stby_fld[0];
  end

  ////////////////////////////////////////////////////////////////////
  // state register

  // single clocked update
  always_ff @(posedge CLK)
  begin
    s_q <= s_d;
  end

  // outputs straight from flops
  assign RD_DATA = s_q.rd_data;
  assign STOP_ENTER = s_q.stop_ent;
  assign WAIT_ENTER = s_q.wait_ent;
  assign REG_STANDBY = s_q.stby_out;
  assign SYS_RESET = s_q.sys_rst;
  assign WDOG_VECTOR = s_q.wdog_vec;

  ////////////////////////////////////////////////////////////////////
  // checks

  chk_stop_gate: assert property (
    @(posedge CLK) disable iff (RST)
    (STOP_EXEC && !s_q.stop_fld[0] && !sys_evt)
    |=> STOP_ENTER
  ) else $error("stop entry not granted");

  chk_wait_block: assert property (
    @(posedge CLK) disable iff (RST)
    (WAIT_EXEC && s_q.wait_fld[0])
    |=> !WAIT_ENTER
  ) else $error("wait entry not blocked");

  chk_stop_lock: assert property (
    @(posedge CLK) disable iff (RST)
    (s_q.stop_fld[1] && !sys_evt)
    |=> $stable(s_q.stop_fld)
  ) else $error("locked stop field changed");

  chk_wait_lock: assert property (
    @(posedge CLK) disable iff (RST)
    (s_q.wait_fld[1] && !sys_evt)
    |=> $stable(s_q.wait_fld)
  ) else $error("locked wait field changed");

  chk_stby_lock: assert property (
    @(posedge CLK) disable iff (RST)
    (s_q.stby_fld[1] && !sys_evt)
    |=> $stable(s_q.stby_fld) && REG_STANDBY == s_q.stby_fld[0]
  ) else $error("locked standby field changed");

  chk_cause_onehot: assert property (
    @(posedge CLK) disable iff (RST)
    sys_evt |=> $onehot(s_q.cause) && SYS_RESET
  ) else $error("cause not one-hot");

  chk_cause_prio: assert property (
    @(posedge CLK) disable iff (RST)
    (WDOG_REFLOSS && WDOG_TIMEOUT && !s_q.ext_s)
    |=> s_q.cause == rlp_pkg::CAUSE_REFLOSS
  ) else $error("reference loss not preferred");

  chk_ext_cause: assert property (
    @(posedge CLK) disable iff (RST)
    s_q.ext_s |=> s_q.cause == rlp_pkg::CAUSE_EXT
  ) else $error("external cause not recorded");

  chk_swr_cause: assert property (
    @(posedge CLK) disable iff (RST)
    (req.wr && req.addr == rlp_pkg::OFF_CTRL
      && req.wdata[rlp_pkg::CTRL_SOFTWARE_RESET_TRIGGER_BIT] && !sys_evt)
    ##1 (!s_q.ext_s && !WDOG_REFLOSS && !WDOG_TIMEOUT)
    |=> s_q.cause == rlp_pkg::CAUSE_SW && SYS_RESET
  ) else $error("software reset not recorded");

  chk_por_value: assert property (
    @(posedge CLK)
    RST |=> s_q.cause == rlp_pkg::CAUSE_POR && !WDOG_VECTOR
  ) else $error("power-on cause wrong");

  chk_scratch_keep: assert property (
    @(posedge CLK) disable iff (RST)
    sys_evt |=> $stable(s_q.scratch)
  ) else $error("scratch lost on system reset");

  chk_wdog_vector: assert property (
    @(posedge CLK) disable iff (RST)
    (WDOG_TIMEOUT && !WDOG_REFLOSS && !s_q.ext_s)
    |=> WDOG_VECTOR && s_q.cause[3]
  ) else $error("watchdog vector not selected");

  chk_software_reset_trigger_rdzero: assert property (
    @(posedge CLK) disable iff (RST)
    (req.rd && req.addr == rlp_pkg::OFF_CTRL)
    |=> RD_DATA[15:4] == 12'h000
  ) else $error("reserved or reset bit reads one");

  chk_wait_gate: assert property (
    @(posedge CLK) disable iff (RST)
    (WAIT_EXEC && !s_q.wait_fld[0] && !sys_evt)
    |=> WAIT_ENTER
  ) else $error("wait entry not granted");

  chk_stop_block: assert property (
    @(posedge CLK) disable iff (RST)
    (STOP_EXEC && s_q.stop_fld[0])
    |=> !STOP_ENTER
  ) else $error("stop entry not blocked");

  chk_field_default: assert property (
    @(posedge CLK) disable iff (RST)
    sys_evt
    |=> s_q.stop_fld == rlp_pkg::FIELD_RST
      && s_q.wait_fld == rlp_pkg::FIELD_RST
      && s_q.stby_fld == rlp_pkg::FIELD_RST
  ) else $error("field not back to default");

  chk_cause_rsvd: assert property (
    @(posedge CLK) disable iff (RST)
    (req.rd && req.addr == rlp_pkg::OFF_CAUSE)
    |=> RD_DATA[15:7] == 9'h000 && RD_DATA[1:0] == 2'h0
  ) else $error("reserved cause bit reads one");

  chk_id_read: assert property (
    @(posedge CLK) disable iff (RST)
    (req.rd && req.addr == rlp_pkg::OFF_CHIP_HI)
    |=> RD_DATA == CHIP_ID_HI
  ) else $error("upper id half wrong");

  chk_scratch_write: assert property (
    @(posedge CLK) disable iff (RST)
    (req.wr && scr_hit && !sys_evt)
    |=> s_q.scratch[$past(scr_idx)] == $past(req.wdata)
  ) else $error("scratch write lost");

  chk_refloss_cause: assert property (
    @(posedge CLK) disable iff (RST)
    (WDOG_REFLOSS && !s_q.ext_s)
    |=> s_q.cause == rlp_pkg::CAUSE_REFLOSS && WDOG_VECTOR
  ) else $error("reference loss not recorded");

endmodule // system_reset_lowpower_ctrl

`default_nettype wire

//--- verilog/rlp_pkg.sv
// package: constants and types of the reset cause and low-power gating block
package rlp_pkg;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam int NUM_SCRATCH = 4;

  // register offsets
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_CAUSE = 5'h01;
  localparam logic [4:0] OFF_SCRATCH = 5'h02;
  localparam logic [4:0] OFF_CHIP_HI = 5'h06;
  localparam logic [4:0] OFF_CHIP_LO = 5'h07;
  localparam logic [4:0] OFF_PWR = 5'h08;

  // field positions
  localparam int CTRL_SOFTWARE_RESET_TRIGGER_BIT = 4;
  localparam int CTRL_STOP_LSB = 2;
  localparam int CTRL_WAIT_LSB = 0;
  localparam int PWR_STBY_LSB = 0;
  localparam int CAUSE_LSB = 2;

  // one-hot cause codes, register bits 2 to 6
  localparam logic [4:0] CAUSE_POR = 5'h01;
  localparam logic [4:0] CAUSE_EXT = 5'h02;
  localparam logic [4:0] CAUSE_REFLOSS = 5'h04;
  localparam logic [4:0] CAUSE_TIMEOUT = 5'h08;
  localparam logic [4:0] CAUSE_SW = 5'h10;

  // reset values
  localparam logic [1:0] FIELD_RST = 2'h0;
  localparam logic [15:0] SCRATCH_RST = 16'h0000;
  localparam logic [4:0] CAUSE_RST = CAUSE_POR;

  typedef logic [1:0] gate_t;

  typedef struct packed {
    logic [4:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } req_t;

  typedef struct packed {
    gate_t stop_fld;
    gate_t wait_fld;
    gate_t stby_fld;
    logic [4:0] cause;
    logic [3:0][15:0] scratch;
    logic swr_pend;
    logic ext_m;
    logic ext_s;
    logic [15:0] rd_data;
    logic stop_ent;
    logic wait_ent;
    logic sys_rst;
    logic wdog_vec;
    logic stby_out;
  } state_t;

endpackage

//--- test/reset_source_model.sv
// model: core instructions, watchdog requests and external reset pin
`timescale 1ns/1ps
`default_nettype none

module reset_source_model
(
  input wire logic clk,
  input wire logic [4:0] req, // ext pin, ref loss, time-out, stop, wait
  output logic ext_n,
  output logic wd_lo,
  output logic wd_to,
  output logic stop_x,
  output logic wait_x
);
  ////////////////////////////////////////////////////////////////
  // quiet sources from time zero, then each request launched just after the edge
  initial
  begin
    {ext_n, wd_lo, wd_to, stop_x, wait_x} = 5'h10;
    forever
    begin
      @(posedge clk);
      ext_n <= ~req[4];
      wd_lo <= req[3];
      wd_to <= req[2];
      stop_x <= req[1];
      wait_x <= req[0];
    end
  end
endmodule // reset_source_model

`default_nettype wire

//--- test/system_reset_lowpower_ctrl_bench.sv
// bench: registers, low-power gating and reset cause of the control block
`timescale 1ns/1ps
`default_nettype none

module system_reset_lowpower_ctrl_bench;
  localparam logic [15:0] ID_HI = 16'h1234; // arbitrary value
  localparam logic [15:0] ID_LO = 16'h4321; // arbitrary value
  logic clk, rst, wr, rd, ext_n, wd_to, wd_lo, stop_x, wait_x;
  logic stop_en, wait_en, stby, sys_rst, wvec;
  logic [4:0] addr, src;
  logic [15:0] wdata, rdata;
  int num_errors, compares;

  // free-running system clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  system_reset_lowpower_ctrl #(.CHIP_ID_HI(ID_HI), .CHIP_ID_LO(ID_LO))
  system_reset_lowpower_ctrl_inst
  (
    .CLK(clk), .RST(rst), .ADDR(addr), .WR_DATA(wdata), .WR_EN(wr), .RD_EN(rd),
    .RD_DATA(rdata), .EXT_RESET_N(ext_n), .WDOG_TIMEOUT(wd_to), .WDOG_REFLOSS(wd_lo),
    .STOP_EXEC(stop_x), .WAIT_EXEC(wait_x), .STOP_ENTER(stop_en), .WAIT_ENTER(wait_en),
    .REG_STANDBY(stby), .SYS_RESET(sys_rst), .WDOG_VECTOR(wvec)
  );

  reset_source_model reset_source_model_inst
  (
    .clk(clk), .req(src), .ext_n(ext_n), .wd_lo(wd_lo), .wd_to(wd_to),
    .stop_x(stop_x), .wait_x(wait_x)
  );

  ////////////////////////////////////////////////////////////////
  // compare, verdict and bus tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    if (num_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  // one-cycle event through the model, sampled after the block captured it
  task automatic fire(input logic [4:0] v);
    @(posedge clk);
    src <= v;
    @(posedge clk);
    src <= '0;
    @(posedge clk) #1;
  endtask

  // bounded wait for the system reset pulse
  task automatic sys_reset_seen();
    int i;
    for (i = 0; i < 6 && sys_rst !== 1'b1; i++)
      @(posedge clk) #1;
    chk({15'h0, sys_rst}, 16'h0001);
    if (sys_rst !== 1'b1)
      stop_test();
  endtask

  ////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_por();
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_reg(5'h01, 16'h0004);
    rd_reg(5'h00, 16'h0000);
    rd_reg(5'h07, ID_LO);
    rd_reg(5'h1F, 16'h0000);
  endtask

  task automatic t_regs();
    int i;
    for (i = 0; i < 4; i++)
      wr_reg(5'h02 + 5'(i), 16'h5A00 + 16'(i));
    wr_reg(5'h06, 16'hFFFF);
    wr_reg(5'h01, 16'h007C);
    for (i = 0; i < 4; i++)
      rd_reg(5'h02 + 5'(i), 16'h5A00 + 16'(i));
    rd_reg(5'h06, ID_HI);
    rd_reg(5'h01, 16'h0004);
  endtask

  task automatic t_gating();
    wr_reg(5'h00, 16'h000B);
    wr_reg(5'h00, 16'h0005);
    rd_reg(5'h00, 16'h000B);
    fire(5'h03);
    chk({14'h0, stop_en, wait_en}, 16'h0002);
    wr_reg(5'h00, 16'h0010);
    sys_reset_seen();
    rd_reg(5'h00, 16'h0000);
    rd_reg(5'h01, 16'h0040);
    wr_reg(5'h00, 16'h0005);
    fire(5'h03);
    chk({14'h0, stop_en, wait_en}, 16'h0000);
    wr_reg(5'h00, 16'h0000);
    fire(5'h03);
    chk({14'h0, stop_en, wait_en}, 16'h0003);
    wr_reg(5'h00, 16'h000E);
    fire(5'h03);
    chk({14'h0, stop_en, wait_en}, 16'h0001);
    wr_reg(5'h00, 16'h0000);
    rd_reg(5'h00, 16'h000E);
  endtask

  task automatic t_regulator();
    wr_reg(5'h08, 16'h0001);
    chk({15'h0, stby}, 16'h0001);
    wr_reg(5'h08, 16'h0000);
    rd_reg(5'h08, 16'h0000);
    wr_reg(5'h08, 16'h0003);
    wr_reg(5'h08, 16'h0000);
    rd_reg(5'h08, 16'h0003);
    chk({15'h0, stby}, 16'h0001);
    fire(5'h04);
    sys_reset_seen();
    rd_reg(5'h08, 16'h0000);
    wr_reg(5'h08, 16'h0002);
    wr_reg(5'h08, 16'h0001);
    rd_reg(5'h08, 16'h0002);
    chk({15'h0, stby}, 16'h0000);
  endtask

  // one reset event and the cause it must leave behind
  task automatic src_case(input logic [4:0] v, input logic [15:0] exp);
    fire(v);
    sys_reset_seen();
    rd_reg(5'h01, exp);
    chk({15'h0, wvec}, {15'h0, |exp[5:4]});
  endtask

  task automatic t_sources();
    src_case(5'h10, 16'h0008);
    src_case(5'h0C, 16'h0010);
    src_case(5'h04, 16'h0020);
    src_case(5'h08, 16'h0010);
    rd_reg(5'h03, 16'h5A01);
  endtask

  // external pin held across a second power-on reset
  task automatic t_por_ext();
    @(posedge clk);
    rst <= 1'b1;
    src <= 5'h10;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    src <= '0;
    @(posedge clk) #1;
    sys_reset_seen();
    repeat (2) @(posedge clk);
    rd_reg(5'h01, 16'h0008);
    rd_reg(5'h02, 16'h0000);
  endtask

  initial
  begin
    {wr, rd, addr, wdata, src} = '0;
    rst = 1'b1;
    num_errors = 0;
    compares = 0;
    t_por();
    t_regs();
    t_gating();
    t_regulator();
    t_sources();
    t_por_ext();
    stop_test();
  end
endmodule // system_reset_lowpower_ctrl_bench

`default_nettype wire
